/* File: windowed_watchdog_control.sv */
`timescale 1ns/1ps
module windowed_watchdog_control
   import wd_pkg::*;
#(
   parameter int PS_W  = PRESCALE_WIDTH,
   parameter int CNT_W = COUNTER_WIDTH
)
(
   input  wire logic            clock,
   input  wire logic            nrst,
   input  wire logic            ce,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [7:0]      paddr,
   input  wire logic [31:0]     pwdata,
   input  wire logic [3:0]      pstrb,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   input  wire wd_pkg::en_mode_t fuse_enable_mode,
   input  wire logic [4:0]      fuse_prescale_default,
   input  wire logic [2:0]      fuse_clock_default,
   input  wire logic [2:0]      fuse_window_default,
   input  wire logic            sleep,
   input  wire logic            clear_watchdog_instruction,
   input  wire logic            low_freq_tick,
   input  wire logic            mid_freq_tick,
   input  wire logic            secondary_tick,
   output logic                 watchdog_reset,
   output logic                 window_violation,
   output logic                 sleep_wake
);

   // ==========================================
   // Decode helpers
   function automatic logic [PS_W-1:0] ps_limit(input logic [4:0] code);
      logic [PS_W-1:0] one;
      one = {{(PS_W-1){1'b0}}, 1'b1};
      if (code > TMO_SEL_MAX) begin
         ps_limit = '0;
      end else begin
         ps_limit = (one << code) - one;
      end
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // ==========================================
   // Registers and wires
   logic [4:0]      timeout_select;
   logic            software_enable_bit;
   logic [2:0]      clock_source_select;
   logic [2:0]      window_select;
   logic [PS_W-1:0] prescale_counter;
   logic [CNT_W-1:0] wd_count;
   logic            armed_reg;
   logic            sleep_reg;
   logic            base_tick;
   logic            active;
   logic            access;
   logic            wr_ctrl0;
   logic            wr_ctrl1;
   logic            rd_ctrl0;
   logic            mapped;
   logic            ps_hit;
   logic            timeout;
   logic            windowed;
   logic            win_open;
   logic            clear_ok;
   logic            violation;
   logic            count_clear;
   logic            ps_free;
   logic            clk_free;
   logic            win_free;
   logic [31:0]     read_next;

   // ==========================================
   // Time base
   wd_clock_pick u_pick (
      .clock               (clock),
      .nrst                (nrst),
      .ce                  (ce),
      .clock_source_select (clock_source_select),
      .low_freq_tick       (low_freq_tick),
      .mid_freq_tick       (mid_freq_tick),
      .secondary_tick      (secondary_tick),
      .base_tick           (base_tick)
   );

   // ==========================================
   // Bus decode, zero wait states
   assign access = psel & penable & ce;
   assign pready = access;
   assign mapped = hit(paddr, OFS_CONTROL_ZERO) | hit(paddr, OFS_CONTROL_ONE)
                 | hit(paddr, OFS_PRESCALE_LOW) | hit(paddr, OFS_PRESCALE_HIGH)
                 | hit(paddr, OFS_COUNTER_STAT);
   assign pslverr  = access & ~mapped;
   assign wr_ctrl0 = access & pwrite & pstrb[0] & hit(paddr, OFS_CONTROL_ZERO);
   assign wr_ctrl1 = access & pwrite & pstrb[0] & hit(paddr, OFS_CONTROL_ONE);
   assign rd_ctrl0 = access & ~pwrite & hit(paddr, OFS_CONTROL_ZERO);

   // Fuses are static straps; locks follow them live
   assign ps_free  = (fuse_prescale_default == FUSE_FREE_5);
   assign clk_free = (fuse_clock_default == FUSE_FREE_3);
   assign win_free = (fuse_window_default == FUSE_FREE_3);

   // ==========================================
   // Enable and window logic
   always_comb begin
      unique case (fuse_enable_mode)
         EN_ALWAYS: active = 1'b1;
         EN_AWAKE:  active = ~sleep;
         EN_SOFT:   active = software_enable_bit;
         EN_OFF:    active = 1'b0;
      endcase
   end

   assign ps_hit   = (prescale_counter == ps_limit(timeout_select));
   assign timeout  = active & base_tick & ps_hit & (&wd_count);
   assign windowed = (window_select != WIN_FULL_OPEN);
   // Open from eighth (7 - code) on: 000 opens last eighth only
   assign win_open = (wd_count[CNT_W-1 -: 3] >= ~window_select);
   assign clear_ok = ~windowed | (armed_reg & win_open);
   assign violation = active & clear_watchdog_instruction & ~clear_ok;

   // Any reason to restart the period
   assign count_clear = ~active | wr_ctrl0 | wr_ctrl1
                      | (sleep != sleep_reg)
                      | (clear_watchdog_instruction & clear_ok)
                      | violation;

   // ==========================================
   // Control register zero
   always_ff @(posedge clock) begin
      if (!nrst) begin
         if (ps_free) begin
            timeout_select <= TMO_SEL_DEFAULT;
         end else begin
            timeout_select <= fuse_prescale_default;
         end
      end else if (ce && wr_ctrl0 && ps_free) begin
         timeout_select <= pwdata[TMO_SEL_LSB +: 5];
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         software_enable_bit <= 1'b0;
      end else if (ce && wr_ctrl0) begin
         software_enable_bit <= pwdata[SW_EN_BIT];
      end
   end

   // ==========================================
   // Control register one
   always_ff @(posedge clock) begin
      if (!nrst) begin
         if (clk_free) begin
            clock_source_select <= CLK_SEL_RESET;
         end else begin
            clock_source_select <= fuse_clock_default;
         end
      end else if (ce && wr_ctrl1 && clk_free) begin
         clock_source_select <= pwdata[CLK_SEL_LSB +: 3];
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         window_select <= fuse_window_default;
      end else if (ce && wr_ctrl1 && win_free) begin
         window_select <= pwdata[WIN_SEL_LSB +: 3];
      end
   end

   // ==========================================
   // Prescaler and watchdog counter
   always_ff @(posedge clock) begin
      if (!nrst) begin
         prescale_counter <= '0;
         wd_count         <= '0;
      end else if (ce) begin
         if (count_clear) begin
            prescale_counter <= '0;
            wd_count         <= '0;
         end else if (active && base_tick) begin
            if (ps_hit) begin
               prescale_counter <= '0;
               wd_count         <= wd_count + 1'b1;
            end else begin
               prescale_counter <= prescale_counter + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         sleep_reg <= 1'b0;
      end else if (ce) begin
         sleep_reg <= sleep;
      end
   end

   // ==========================================
   // Arming: a read arms, a clear disarms; set wins
   always_ff @(posedge clock) begin
      if (!nrst) begin
         armed_reg <= 1'b0;
      end else if (ce) begin
         if (rd_ctrl0) begin
            armed_reg <= 1'b1;
         end else if (clear_watchdog_instruction) begin
            armed_reg <= 1'b0;
         end
      end
   end

   // ==========================================
   // Event outputs, one-cycle pulses
   // A time-out while asleep wakes instead of resetting
   always_ff @(posedge clock) begin
      if (!nrst) begin
         watchdog_reset   <= 1'b0;
         window_violation <= 1'b0;
         sleep_wake       <= 1'b0;
      end else if (ce) begin
         watchdog_reset   <= (timeout & ~sleep) | violation;
         window_violation <= violation;
         sleep_wake       <= timeout & sleep;
      end
   end

   // ==========================================
   // Read data, captured in the setup phase
   always_comb begin
      read_next = 32'h0000_0000;
      if (hit(paddr, OFS_CONTROL_ZERO)) begin
         read_next[TMO_SEL_LSB +: 5] = timeout_select;
         read_next[SW_EN_BIT]        = software_enable_bit;
      end else if (hit(paddr, OFS_CONTROL_ONE)) begin
         read_next[CLK_SEL_LSB +: 3] = clock_source_select;
         read_next[WIN_SEL_LSB +: 3] = window_select;
      end else if (hit(paddr, OFS_PRESCALE_LOW)) begin
         read_next[7:0] = prescale_counter[7:0];
      end else if (hit(paddr, OFS_PRESCALE_HIGH)) begin
         read_next[7:0] = prescale_counter[15:8];
      end else if (hit(paddr, OFS_COUNTER_STAT)) begin
         read_next[1:0]       = prescale_counter[17:16];
         read_next[ARMED_BIT] = armed_reg;
         read_next[COUNT_LSB +: STATUS_COUNT_W] = wd_count[STATUS_COUNT_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (ce && psel && !penable) begin
         prdata <= read_next;
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence s_ctrl0_write;
      ce && wr_ctrl0;
   endsequence

   sequence s_ctrl1_write;
      ce && wr_ctrl1;
   endsequence

   property p_reserved_min;
      (timeout_select > TMO_SEL_MAX) |-> (ps_limit(timeout_select) == '0);
   endproperty
   a_reserved_min: assert property (p_reserved_min) else $error("reserved code not minimum");

   property p_prescale_bound;
      prescale_counter <= ps_limit(timeout_select);
   endproperty
   a_prescale_bound: assert property (p_prescale_bound) else $error("prescaler past ratio");

   property p_select_locked;
      s_ctrl0_write ##0 !ps_free |=> $stable(timeout_select);
   endproperty
   a_select_locked: assert property (p_select_locked) else $error("locked select changed");

   property p_clock_locked;
      s_ctrl1_write ##0 !clk_free |=> $stable(clock_source_select);
   endproperty
   a_clock_locked: assert property (p_clock_locked) else $error("locked clock changed");

   property p_window_locked;
      s_ctrl1_write ##0 !win_free |=> $stable(window_select);
   endproperty
   a_window_locked: assert property (p_window_locked) else $error("locked window changed");

   property p_write_clears;
      (s_ctrl0_write or s_ctrl1_write) |=> (wd_count == '0) && (prescale_counter == '0);
   endproperty
   a_write_clears: assert property (p_write_clears) else $error("write kept counter");

   property p_read_arms;
      (ce && rd_ctrl0) |=> armed_reg ##1 (armed_reg || $past(clear_watchdog_instruction));
   endproperty
   a_read_arms: assert property (p_read_arms) else $error("read did not arm");

   property p_violation_reset;
      (ce && active && clear_watchdog_instruction && windowed && !armed_reg)
         |=> watchdog_reset && window_violation;
   endproperty
   a_violation_reset: assert property (p_violation_reset) else $error("no reset on violation");

   property p_mode_off;
      (fuse_enable_mode == EN_OFF) |-> !active ##1 (wd_count == '0);
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("watchdog ran while off");

   property p_soft_mode;
      (fuse_enable_mode == EN_SOFT) |-> (active == software_enable_bit);
   endproperty
   a_soft_mode: assert property (p_soft_mode) else $error("software enable ignored");

   property p_timeout_pulse;
      (ce && timeout && !sleep) |=> watchdog_reset;
   endproperty
   a_timeout_pulse: assert property (p_timeout_pulse) else $error("time-out gave no reset");

   property p_open_clear;
      (ce && active && clear_watchdog_instruction && windowed && armed_reg && win_open) |=> !window_violation;
   endproperty
   a_open_clear: assert property (p_open_clear) else $error("valid clear flagged");

   // Checks reset itself, so it must never be disabled
   property p_fuse_default;
      @(posedge clock) disable iff (1'b0)
         (!nrst && fuse_prescale_default == FUSE_FREE_5) |=> (timeout_select == TMO_SEL_DEFAULT);
   endproperty
   a_fuse_default: assert property (p_fuse_default) else $error("bad default");

endmodule

/* File: wd_pkg.sv */
// Summary of operation
// - Select code doubles ratio, 1:32 up to 2^23
// - Codes 10011 to 11111 act as 1:32
// - Code 01011 is 1:65536, reset default
// - Fuse all ones loads 01011, else fuse
// - Select field locked unless fuse all ones
// - Software enable counts only in mode 01
// - Control zero: select 5:1, enable 0
// - Clock select bits 6:4, three sources
// - Clock fuse 111 resets select to 000
// - Clock select locked unless fuse 111
// - Window code sets closed delay eighths
// - Window select resets from window fuse
// - Window select locked unless fuse 111
// - Prescale counter readable over three registers
// - Timer register shows counter bits 3:0 in bits 6:3, bit 7 zero
// - Timer bit 2 shows armed state
// - Nominal intervals assume 31 kHz base
// - Clear outside open window causes reset
// - Read control zero arms; unarmed clear violates unless window code is 111
// - Control register write clears watchdog counter
// - Enable mode selects always, awake, software, off
package wd_pkg;

   // ==========================================
   // Register map, byte addresses
   localparam logic [7:0] OFS_CONTROL_ZERO = 8'h00;
   localparam logic [7:0] OFS_CONTROL_ONE  = 8'h04;
   localparam logic [7:0] OFS_PRESCALE_LOW = 8'h08;
   localparam logic [7:0] OFS_PRESCALE_HIGH = 8'h0C;
   localparam logic [7:0] OFS_COUNTER_STAT = 8'h10;

   // ==========================================
   // Field positions
   localparam int TMO_SEL_LSB  = 1;
   localparam int SW_EN_BIT    = 0;
   localparam int CLK_SEL_LSB  = 4;
   localparam int WIN_SEL_LSB  = 0;
   localparam int ARMED_BIT    = 2;
   localparam int COUNT_LSB    = 3;

   // ==========================================
   // Codes and reset values
   localparam logic [4:0] TMO_SEL_DEFAULT = 5'h0B;
   localparam logic [4:0] TMO_SEL_MAX     = 5'h12;
   localparam logic [4:0] FUSE_FREE_5     = 5'h1F;
   localparam logic [2:0] FUSE_FREE_3     = 3'h7;
   localparam logic [2:0] CLK_SEL_RESET   = 3'h0;
   localparam logic [2:0] CLK_LOW_FREQ    = 3'h0;
   localparam logic [2:0] CLK_MID_FREQ    = 3'h1;
   localparam logic [2:0] CLK_SECONDARY   = 3'h2;
   localparam logic [2:0] WIN_FULL_OPEN   = 3'h7;

   // ==========================================
   // Timing: ratio 2^(5+code), split as
   // prescaler 2^code and 32 counter steps
   localparam int PRESCALE_WIDTH = 18;
   localparam int COUNTER_WIDTH  = 5;
   localparam int STATUS_COUNT_W = 4;
   localparam int NOMINAL_BASE_HZ = 31000;

   typedef enum logic [1:0] {
      EN_OFF    = 2'b00,
      EN_SOFT   = 2'b01,
      EN_AWAKE  = 2'b10,
      EN_ALWAYS = 2'b11
   } en_mode_t;

endpackage

/* File: wd_clock_pick.sv */
`timescale 1ns/1ps
module wd_clock_pick
   import wd_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic       ce,
   input  wire logic [2:0] clock_source_select,
   input  wire logic       low_freq_tick,
   input  wire logic       mid_freq_tick,
   input  wire logic       secondary_tick,
   output logic            base_tick
);

   logic tick_next;

   // ==========================================
   // Source select
   always_comb begin
      unique case (clock_source_select)
         CLK_LOW_FREQ:  tick_next = low_freq_tick;
         CLK_MID_FREQ:  tick_next = mid_freq_tick;
         CLK_SECONDARY: tick_next = secondary_tick;
         default:       tick_next = 1'b0;
      endcase
   end

   // Reserved codes stall the time base
   always_ff @(posedge clock) begin
      if (!nrst) begin
         base_tick <= 1'b0;
      end else if (ce) begin
         base_tick <= tick_next;
      end
   end

endmodule

/* File: tb_windowed_watchdog_control.sv */
`timescale 1ns/1ps
module tb_windowed_watchdog_control;
   import wd_pkg::*;
   // ==========================================
   // Signals
   logic        clock, nrst, ce, psel, penable, pwrite, sleep, clr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic [3:0]  pstrb;
   logic        pready, pslverr, watchdog_reset, window_violation, sleep_wake;
   logic [4:0]  fps, p;
   logic [2:0]  fcs, fws, tk, c, w;
   en_mode_t    fem;
   int          n_mismatch, checked, seed, cyc, i;
   logic [4:0]  codes [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h13, 5'h1F, 5'h00};

   windowed_watchdog_control dut (
      .clock(clock), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fuse_enable_mode(fem), .fuse_prescale_default(fps),
      .fuse_clock_default(fcs), .fuse_window_default(fws), .sleep(sleep),
      .clear_watchdog_instruction(clr), .low_freq_tick(tk[0]),
      .mid_freq_tick(tk[1]), .secondary_tick(tk[2]),
      .watchdog_reset(watchdog_reset), .window_violation(window_violation),
      .sleep_wake(sleep_wake));

   initial begin
      clock = 1'h0;
      forever #4 clock = ~clock;
   end

   // ==========================================
   // Checking and closing
   task automatic final_report();
      $display("Counts: %0d checked, %0d mismatched", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic timeout(input int got, input int exp);
      n_mismatch++;
      $display("MISMATCH t=%0t wait ran out got %h exp %h", $time, got, exp);
      final_report();
   endtask

   task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk_count(input int g, input int e);
      checked++;
      if (g != e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   function automatic int period(input logic [4:0] code);
      return (code > 5'h12) ? 32 : (32 << code);
   endfunction

   function automatic logic active(input en_mode_t m, input logic s, input logic e);
      return m == EN_ALWAYS || (m == EN_AWAKE && !s) || (m == EN_SOFT && e);
   endfunction

   // ==========================================
   // Drivers
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int j;
      @(posedge clock);
      psel    <= 1'h1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'h1;
      for (j = 0; j < 20; j++) begin
         @(posedge clock);
         if (pready === 1'h1) break;
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      if (j == 20) timeout(j, 0);
   endtask

   task automatic do_reset(input en_mode_t m, input logic [4:0] fp, input logic [2:0] fc,
                           input logic [2:0] fw);
      @(posedge clock);
      nrst <= 1'h0;
      fem  <= m;
      fps  <= fp;
      fcs  <= fc;
      fws  <= fw;
      repeat (2) @(posedge clock);
      nrst <= 1'h1;
   endtask

   // Stops at a reset or wake pulse; cyc is bound+1 when none came
   task automatic wait_evt(input int bound, input logic must);
      for (cyc = 1; cyc <= bound; cyc++) begin
         @(posedge clock);
         #1;
         if (watchdog_reset === 1'h1 || sleep_wake === 1'h1) break;
      end
      if (must && cyc > bound) timeout(cyc, bound);
   endtask

   task automatic pulse_clear(input logic e);
      @(posedge clock);
      clr <= 1'h1;
      @(posedge clock);
      clr <= 1'h0;
      #1;
      chk_data({30'h0, window_violation, watchdog_reset}, {30'h0, e, e});
   endtask

   initial begin
      #400000;
      timeout(0, 1);
   end

   // ==========================================
   // Main sequence
   initial begin
      seed = 52;
      n_mismatch = 0;
      checked = 0;
      nrst <= 1'h0;
      ce <= 1'h1;
      psel <= 1'h0;
      penable <= 1'h0;
      pwrite <= 1'h0;
      paddr <= 8'h00;
      pwdata <= 32'h0;
      pstrb <= 4'hF;
      sleep <= 1'h0;
      clr <= 1'h0;
      tk <= 3'h0;
      do_reset(EN_OFF, 5'h1F, 3'h7, 3'h7);
      apb(1'h0, OFS_COUNTER_STAT, 32'h0);
      chk_data(rd, 32'h00);
      apb(1'h0, OFS_CONTROL_ZERO, 32'h0);
      chk_data(rd, 32'h16);
      apb(1'h0, OFS_CONTROL_ONE, 32'h0);
      chk_data(rd, 32'h07);
      apb(1'h0, OFS_COUNTER_STAT, 32'h0);
      chk_data(rd, 32'h04);
      apb(1'h1, OFS_PRESCALE_LOW, 32'hFF);
      apb(1'h0, OFS_PRESCALE_LOW, 32'h0);
      chk_data(rd, 32'h00);
      apb(1'h0, OFS_PRESCALE_HIGH, 32'h0);
      chk_data(rd, 32'h00);
      apb(1'h1, 8'h14, 32'hFF);
      chk_data({31'h0, err}, 32'h1);
      apb(1'h0, 8'h14, 32'h0);
      chk_data({rd[30:0], err}, 32'h1);
      for (i = 0; i < 4; i++) begin
         v = $random(seed);
         apb(1'h1, OFS_CONTROL_ZERO, v);
         apb(1'h0, OFS_CONTROL_ZERO, 32'h0);
         chk_data(rd, v & 32'h3F);
         apb(1'h1, OFS_CONTROL_ONE, v);
         apb(1'h0, OFS_CONTROL_ONE, 32'h0);
         chk_data(rd, v & 32'h77);
      end
      $display("test unlocked registers done");
      for (i = 0; i < 3; i++) begin
         v = $random(seed);
         p = (v[4:0] == 5'h1F) ? 5'h00 : v[4:0];
         c = (v[10:8] == 3'h7) ? 3'h0 : v[10:8];
         w = (v[14:12] == 3'h7) ? 3'h0 : v[14:12];
         do_reset(EN_OFF, p, c, w);
         apb(1'h0, OFS_CONTROL_ZERO, 32'h0);
         chk_data(rd, {26'h0, p, 1'h0});
         apb(1'h1, OFS_CONTROL_ZERO, {26'h0, ~p, 1'h1});
         apb(1'h0, OFS_CONTROL_ZERO, 32'h0);
         chk_data(rd, {26'h0, p, 1'h1});
         apb(1'h0, OFS_CONTROL_ONE, 32'h0);
         chk_data(rd, {25'h0, c, 1'h0, w});
         apb(1'h1, OFS_CONTROL_ONE, {25'h0, ~c, 1'h0, ~w});
         apb(1'h0, OFS_CONTROL_ONE, 32'h0);
         chk_data(rd, {25'h0, c, 1'h0, w});
      end
      $display("test locked fields done");
      do_reset(EN_ALWAYS, 5'h1F, 3'h7, 3'h7);
      tk <= 3'h1;
      codes[6] = 5'($unsigned($random(seed)) % 4);
      for (i = 0; i < 7; i++) begin
         apb(1'h1, OFS_CONTROL_ZERO, {26'h0, codes[i], 1'h0});
         wait_evt(5000, 1'h1);
         wait_evt(5000, 1'h1);
         chk_count(cyc, period(codes[i]));
      end
      apb(1'h1, OFS_CONTROL_ZERO, 32'h04);
      repeat (40) @(posedge clock);
      apb(1'h1, OFS_CONTROL_ZERO, 32'h04);
      apb(1'h0, OFS_COUNTER_STAT, 32'h0);
      chk_data(rd & 32'hFFFFFFFB, 32'h0);
      apb(1'h1, OFS_CONTROL_ZERO, 32'h16);
      repeat (380) @(posedge clock);
      apb(1'h0, OFS_PRESCALE_HIGH, 32'h0);
      chk_data(rd, 32'h01);
      @(posedge clock);
      ce <= 1'h0;
      repeat (50) @(posedge clock);
      ce <= 1'h1;
      apb(1'h0, OFS_PRESCALE_LOW, 32'h0);
      chk_data(rd, 32'h81);
      $display("test periods done");
      apb(1'h1, OFS_CONTROL_ZERO, 32'h00);
      for (i = 0; i < 4; i++) begin
         apb(1'h1, OFS_CONTROL_ONE, {25'h0, 3'(i), 4'h7});
         tk <= (i == 3) ? 3'h7 : 3'(1 << ((i + 1) % 3));
         wait_evt(100, 1'h0);
         chk_count(cyc, 101);
         if (i < 3) begin
            tk <= 3'(1 << i);
            wait_evt(100, 1'h1);
            chk_data({31'h0, watchdog_reset}, 32'h1);
         end
      end
      tk <= 3'h1;
      $display("test clock select done");
      for (i = 0; i < 16; i++) begin
         do_reset(en_mode_t'(i[3:2]), 5'h1F, 3'h7, 3'h7);
         sleep <= i[1];
         apb(1'h1, OFS_CONTROL_ZERO, {31'h0, i[0]});
         wait_evt(100, 1'h0);
         chk_data({30'h0, watchdog_reset, sleep_wake},
                  {30'h0, active(en_mode_t'(i[3:2]), i[1], i[0]) & !i[1],
                   active(en_mode_t'(i[3:2]), i[1], i[0]) & i[1]});
      end
      sleep <= 1'h0;
      $display("test enable modes done");
      do_reset(EN_ALWAYS, 5'h1F, 3'h7, 3'h7);
      apb(1'h1, OFS_CONTROL_ZERO, 32'h02);
      repeat (10) @(posedge clock);
      pulse_clear(1'h0);
      apb(1'h1, OFS_CONTROL_ONE, 32'h00);
      pulse_clear(1'h1);
      apb(1'h0, OFS_CONTROL_ZERO, 32'h0);
      pulse_clear(1'h1);
      apb(1'h1, OFS_CONTROL_ONE, 32'h00);
      repeat (56) @(posedge clock);
      apb(1'h0, OFS_CONTROL_ZERO, 32'h0);
      pulse_clear(1'h0);
      wait_evt(40, 1'h0);
      chk_count(cyc, 41);
      $display("test window done");
      final_report();
   end
endmodule
